/* verilog/srap_top.sv */
// serial register access port: four-wire spi slave and i2c slave
// Operation
// [RULE1] start is data falling while clock high
// [RULE2] ack: receiver holds data low, ninth clock
// [RULE3] data high on ninth clock ends read
// [RULE4] stop is data rising while clock high
// [RULE5] slave only, never drives clock or select; the i2c side still pulls the clock low to stretch
// [RULE6] master frames each transfer with select low
// [RULE7] master selects only one slave at once
// [RULE8] output released while select is high
// [RULE9] bytes shift most significant bit first
// [RULE10] receiver samples data on rising clock
// [RULE11] transmitter changes data on falling clock
// [RULE12] master keeps serial clock at most 8 MHz
// [RULE13] transfer is address byte plus data bytes
// [RULE14] first address bit one reads, zero writes
// [RULE15] next seven bits give register index
// [RULE16] following bytes carry data bit 7 first
// [RULE17] single and burst transfers both accepted
// [RULE18] index advances by one per data byte; i2c does not advance it after a nacked read byte
// [RULE19] i2c address 110100 plus select pin
// [RULE20] master reads via index write, repeated start
// [RULE21] read data starts after last address bit
`timescale 1ns/1ps
module srap_top
    import srap_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic cs_n,
    input wire logic sclk_scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic address_select_pin,
    output logic sdo_out,
    output logic sdo_oe,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [IDX_W-1:0] wr_index,
    output logic [DATA_W-1:0] wr_data,
    output logic [IDX_W-1:0] rd_index,
    input wire logic [DATA_W-1:0] rd_data,
    output logic spi_overrun
);

    // =========================================================
    // pin synchronisers
    // the serial clock is only sampled, so it must stay slow
    // against clk; see [RULE12]
    logic [PIN_N-1:0] pins_raw;
    logic [PIN_N-1:0] pin_s;

    assign pins_raw = {address_select_pin, sda_in, sclk_scl_in, cs_n};

    generate
        for (genvar g = 0; g < PIN_N; g++) begin : g_sync
            logic stage1;
            logic stage2;
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    stage1 <= PIN_IDLE[g];
                    stage2 <= PIN_IDLE[g];
                end else if (ce) begin
                    stage1 <= pins_raw[g];
                    stage2 <= stage1;
                end
            end
            assign pin_s[g] = stage2;
        end
    endgenerate

    logic scl_q;
    logic sda_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (ce) begin
            scl_q <= pin_s[PIN_SCL];
            sda_q <= pin_s[PIN_SDA];
        end
    end

    // =========================================================
    // edge and condition decode
    wire scl = pin_s[PIN_SCL];
    wire sda = pin_s[PIN_SDA];
    wire cs_lo = ~pin_s[PIN_CS];
    wire asel = pin_s[PIN_ASEL];
    wire scl_rise = srap_rise(scl, scl_q);
    wire scl_fall = srap_rise(scl_q, scl);
    wire spi_rise = cs_lo & scl_rise;
    wire spi_fall = cs_lo & scl_fall;
    // i2c only listens while the spi select is idle
    wire i2c_on = ~cs_lo;
    wire scl_high = scl & scl_q;
    wire i2c_start = i2c_on & scl_high & srap_rise(sda_q, sda); // see [RULE1]
    wire i2c_stop = i2c_on & scl_high & srap_rise(sda, sda_q); // see [RULE4]

    // =========================================================
    // write buffer
    logic s_push;
    logic [FIFO_W-1:0] s_pdata;
    logic i_push_pend;
    logic [FIFO_W-1:0] i_pdata;
    logic fifo_in_ready;

    wire i_push = i_push_pend & fifo_in_ready;
    wire fifo_in_valid = s_push | i_push;
    wire [FIFO_W-1:0] fifo_in_data = s_push ? s_pdata : i_pdata;

    srap_fifo #(
        .W(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .in_valid(fifo_in_valid),
        .in_data(fifo_in_data),
        .in_ready(fifo_in_ready),
        .out_valid(wr_valid),
        .out_data({wr_index, wr_data}),
        .out_ready(wr_ready)
    );

    // =========================================================
    // spi receive side
    srap_spi_e s_state;
    logic [2:0] s_cnt;
    logic [6:0] s_sh;
    logic s_read;
    logic [IDX_W-1:0] s_index;
    logic [6:0] s_tx;

    wire [DATA_W-1:0] s_byte = {s_sh, sda}; // see [RULE9]
    wire s_done = spi_rise & (s_cnt == BIT_LAST);
    wire s_in_data = (s_state == SPI_DATA);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_state <= SPI_IDLE;
            s_cnt <= BIT_FIRST;
            s_sh <= '0;
            s_read <= 1'b0;
            s_index <= '0;
            s_push <= 1'b0;
            s_pdata <= '0;
        end else if (ce) begin
            s_push <= 1'b0;
            if (!cs_lo) begin
                // a byte cut short by select rising is dropped
                s_state <= SPI_IDLE; // see [RULE6] see [RULE13]
                s_cnt <= BIT_FIRST;
            end else begin
                if (s_state == SPI_IDLE) begin
                    s_state <= SPI_ADDR;
                end
                if (spi_rise) begin
                    s_sh <= s_byte[6:0]; // see [RULE10]
                    s_cnt <= s_cnt + 1'b1;
                end
                if (s_done && s_in_data) begin
                    s_index <= s_index + 1'b1; // see [RULE18] see [RULE17]
                    if (!s_read) begin
                        s_push <= 1'b1;
                        s_pdata <= {s_index, s_byte}; // see [RULE16]
                    end
                end else if (s_done) begin
                    s_read <= (s_byte[DIR_BIT] == DIR_READ); // see [RULE14]
                    s_index <= s_byte[IDX_W-1:0]; // see [RULE15]
                    s_state <= SPI_DATA;
                end
            end
        end
    end

    // =========================================================
    // spi transmit side
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sdo_out <= 1'b0;
            sdo_oe <= 1'b0;
            s_tx <= '0;
        end else if (ce) begin
            if (!cs_lo) begin
                sdo_oe <= 1'b0; // see [RULE8]
            end else if (spi_fall && s_in_data && s_read) begin
                sdo_oe <= 1'b1; // see [RULE5]
                if (s_cnt == BIT_FIRST) begin
                    sdo_out <= rd_data[DATA_W-1]; // see [RULE21]
                    s_tx <= rd_data[6:0];
                end else begin
                    sdo_out <= s_tx[6]; // see [RULE11] see [RULE9]
                    s_tx <= {s_tx[5:0], 1'b0};
                end
            end
        end
    end

    // overrun stays up until the next frame begins; set wins
    wire s_lost = s_push & ~fifo_in_ready;
    wire s_frame_new = cs_lo & (s_state == SPI_IDLE);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            spi_overrun <= 1'b0;
        end else if (ce) begin
            if (s_lost) begin
                spi_overrun <= 1'b1;
            end else if (s_frame_new) begin
                spi_overrun <= 1'b0;
            end
        end
    end

    // =========================================================
    // i2c byte engine
    srap_i2c_e i_state;
    logic [3:0] i_cnt;
    logic [6:0] i_sh;
    logic [IDX_W-1:0] i_index;
    logic i_ack_pend;
    logic i_tx_act;
    logic [6:0] i_tx;

    wire [DATA_W-1:0] i_byte = {i_sh, sda};
    wire i_busy = (i_state != I2C_IDLE);
    wire i_bit_rise = scl_rise & i_busy;
    wire i_done = i_bit_rise & (i_cnt == I2C_CNT_LAST);
    wire i_nine = i_bit_rise & (i_cnt == I2C_CNT_ACK);
    wire dev_hit = (i_byte[DATA_W-1:1] == {I2C_ADDR_HI, asel}); // see [RULE19]
    wire i_nack = i_nine & i_tx_act & sda; // see [RULE3]

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            i_state <= I2C_IDLE;
            i_cnt <= I2C_CNT_FIRST;
            i_sh <= '0;
            i_index <= '0;
            i_ack_pend <= 1'b0;
            i_push_pend <= 1'b0;
            i_pdata <= '0;
        end else if (ce) begin
            if (i_push) begin
                i_push_pend <= 1'b0;
            end
            if (!i2c_on || i2c_stop) begin
                i_state <= I2C_IDLE; // see [RULE4]
                i_ack_pend <= 1'b0;
            end else if (i2c_start) begin
                // a repeated start keeps the stored index
                i_state <= I2C_DEV; // see [RULE1] see [RULE20]
                i_cnt <= I2C_CNT_FIRST;
                i_ack_pend <= 1'b0;
            end else if (i_nine) begin
                i_cnt <= I2C_CNT_FIRST;
                i_ack_pend <= 1'b0;
                if (i_nack) begin
                    i_state <= I2C_IDLE; // see [RULE3]
                end else if (i_tx_act) begin
                    i_index <= i_index + 1'b1; // see [RULE18]
                end
            end else if (i_bit_rise) begin
                i_sh <= i_byte[6:0];
                i_cnt <= i_cnt + 1'b1;
                if (i_done) begin
                    case (i_state)
                        I2C_DEV: begin
                            i_ack_pend <= dev_hit;
                            if (!dev_hit) begin
                                i_state <= I2C_IDLE;
                            end else if (i_byte[0] == DIR_READ) begin
                                i_state <= I2C_RD;
                            end else begin
                                i_state <= I2C_REG;
                            end
                        end
                        I2C_REG: begin
                            i_index <= i_byte[IDX_W-1:0];
                            i_ack_pend <= 1'b1;
                            i_state <= I2C_WR;
                        end
                        I2C_WR: begin
                            i_pdata <= {i_index, i_byte};
                            i_push_pend <= 1'b1;
                            i_index <= i_index + 1'b1; // see [RULE18]
                            i_ack_pend <= 1'b1;
                        end
                        default: begin
                            i_ack_pend <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // =========================================================
    // i2c data line drive, open drain: enable pulls low
    wire i_rd_now = (i_state == I2C_RD);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sda_oe <= 1'b0;
            i_tx <= '0;
            i_tx_act <= 1'b0;
        end else if (ce) begin
            if (!i2c_on || i2c_stop || i2c_start || !i_rd_now) begin
                i_tx_act <= 1'b0;
            end
            if (!i2c_on || i2c_stop || i2c_start) begin
                sda_oe <= 1'b0;
            end else if (scl_fall) begin
                if (i_cnt == I2C_CNT_ACK) begin
                    sda_oe <= i_ack_pend; // see [RULE2]
                end else if (i_rd_now && i_cnt == I2C_CNT_FIRST) begin
                    sda_oe <= ~rd_data[DATA_W-1]; // see [RULE11]
                    i_tx <= rd_data[6:0];
                    i_tx_act <= 1'b1;
                end else if (i_rd_now && i_tx_act) begin
                    sda_oe <= ~i_tx[6]; // see [RULE9]
                    i_tx <= {i_tx[5:0], 1'b0};
                end else begin
                    sda_oe <= 1'b0;
                end
            end
        end
    end

    // =========================================================
    // clock stretch while a received byte waits for buffer room;
    // only grabbed once the master has pulled the clock low
    wire stretch_need = i_push_pend & ~fifo_in_ready;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            scl_oe <= 1'b0;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end else if (ce) begin
            scl_oe <= stretch_need & (scl_oe | ~scl);
        end
    end

    // =========================================================
    // read index toward the register file
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_index <= '0;
        end else if (ce) begin
            rd_index <= cs_lo ? s_index : i_index;
        end
    end

endmodule : srap_top

/* inc/srap_pkg.sv */
// shared constants and types of the serial register access port
package srap_pkg;

    // =========================================================
    // widths and buffer shape
    localparam int IDX_W = 7;
    localparam int DATA_W = 8;
    localparam int FIFO_W = IDX_W + DATA_W;
    localparam int FIFO_DEPTH = 16;

    // =========================================================
    // pin positions in the synchroniser vector
    localparam int PIN_CS = 0;
    localparam int PIN_SCL = 1;
    localparam int PIN_SDA = 2;
    localparam int PIN_ASEL = 3;
    localparam int PIN_N = 4;
    // idle levels: chip select, clock and data high, address select low
    localparam logic [PIN_N-1:0] PIN_IDLE = 4'h7;

    // =========================================================
    // framing
    localparam int DIR_BIT = 7;
    localparam logic DIR_READ = 1'b1;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [3:0] I2C_CNT_FIRST = 4'h0;
    localparam logic [3:0] I2C_CNT_LAST = 4'h7;
    localparam logic [3:0] I2C_CNT_ACK = 4'h8;
    localparam logic [5:0] I2C_ADDR_HI = 6'h34;

    // =========================================================
    // timing: fastest serial clock against the sampling clock
    localparam int CLK_HZ = 25_000_000;
    localparam int SCLK_MAX_HZ = 8_000_000;
    localparam int CLK_PER_SCLK = CLK_HZ / SCLK_MAX_HZ;

    // =========================================================
    // state encodings
    typedef enum logic [1:0] {
        SPI_IDLE = 2'h0,
        SPI_ADDR = 2'h1,
        SPI_DATA = 2'h3
    } srap_spi_e;

    typedef enum logic [2:0] {
        I2C_IDLE = 3'h0,
        I2C_DEV = 3'h1,
        I2C_REG = 3'h3,
        I2C_WR = 3'h2,
        I2C_RD = 3'h6
    } srap_i2c_e;

    // level went from low (prev) to high (cur)
    function automatic logic srap_rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction : srap_rise

endpackage : srap_pkg

/* verilog/srap_fifo.sv */
// write-data buffer with a registered output stage
`timescale 1ns/1ps
module srap_fifo
    import srap_pkg::*;
#(
    parameter int W = FIFO_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] count;

    wire push = in_valid & in_ready;
    wire load = (count != '0) & (~out_valid | out_ready);
    assign in_ready = (count != CW'(DEPTH));

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wptr] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (ce) begin
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            if (load) begin
                rptr <= rptr + 1'b1;
                out_data <= mem[rptr];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
        end
    end

endmodule : srap_fifo

/* testbench/srap_top_sva.sv */
// concurrent checks on the pins of the serial register access port
`timescale 1ns/1ps
module srap_top_sva
    import srap_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic sclk_scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic [IDX_W-1:0] wr_index,
    input wire logic [DATA_W-1:0] wr_data
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // ========
    // pin runs: three flops of latency, so six samples is settled
    sequence cs_idle_run;
        cs_n [*6];
    endsequence
    sequence cs_busy_run;
        !cs_n [*6];
    endsequence
    sequence sclk_high_run;
        (sclk_scl_in && !cs_n) [*2];
    endsequence
    sequence wr_stall;
        wr_valid && !wr_ready;
    endsequence
    sequence wr_kept;
        wr_valid && $stable(wr_index) && $stable(wr_data);
    endsequence

    // ========
    // checks
    chk_sdo_released: assert property (cs_idle_run |-> !sdo_oe)
        else $error("sdo driven while deselected");
    chk_sdo_needs_cs: assert property ($rose(sdo_oe) |-> !cs_n)
        else $error("sdo enabled without select");
    chk_scl_open_drain: assert property (scl_out == 1'b0)
        else $error("scl driven high");
    chk_sda_open_drain: assert property (sda_out == 1'b0)
        else $error("sda driven high");
    chk_spi_no_stretch: assert property (cs_busy_run |-> !scl_oe)
        else $error("clock pulled in spi mode");
    chk_spi_sda_free: assert property (cs_busy_run |-> !sda_oe)
        else $error("sda pulled in spi mode");
    chk_wr_word_held: assert property (wr_stall |=> wr_kept)
        else $error("write word changed before taken");
    chk_sdo_steady_high: assert property (sclk_high_run |-> $stable(sdo_out))
        else $error("sdo moved while sclk high");
    chk_ack_scl_low: assert property ($rose(sda_oe) |-> !sclk_scl_in)
        else $error("sda pulled while scl high");
endmodule : srap_top_sva

/* testbench/srap_host.sv */
// host model driving spi and i2c frames toward the port
`timescale 1ns/1ps
module srap_host (
    input wire logic clk,
    output logic cs_n,
    output logic sck,
    output logic sd,
    input wire logic sdo_line,
    input wire logic sda_line,
    input wire logic scl_line
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b1;
        sd = 1'b1;
    end
    // half period of 4 clocks: 3.125 MHz, under the limit
    task automatic half();
        repeat (4) @(negedge clk);
    endtask : half
    task automatic select(input logic v);
        cs_n = v;
        half();
        sd = 1'b1;
        half();
    endtask : select
    task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck = 1'b0;
            sd = tx[i];
            half();
            rx = {rx[6:0], sdo_line};
            sck = 1'b1;
            half();
        end
    endtask : spi_byte
    task automatic i2c_bit(input logic b, output logic s);
        half();
        sd = b;
        half();
        sck = 1'b1;
        // the slave may stretch the clock; bounded wait
        for (int w = 0; w < 400 && scl_line !== 1'b1; w++) @(negedge clk);
        half();
        s = sda_line;
        sck = 1'b0;
    endtask : i2c_bit
    task automatic i2c_byte(input logic [7:0] tx, input logic ack, output logic [7:0] rx, output logic ackd);
        for (int i = 7; i >= 0; i--) i2c_bit(tx[i], rx[i]);
        i2c_bit(ack, ackd);
    endtask : i2c_byte
    task automatic start();
        half();
        sd = 1'b1;
        half();
        sck = 1'b1;
        half();
        sd = 1'b0;
        half();
        sck = 1'b0;
    endtask : start
    task automatic stop();
        half();
        sd = 1'b0;
        half();
        sck = 1'b1;
        half();
        sd = 1'b1;
        half();
    endtask : stop
endmodule : srap_host

/* testbench/serial_register_access_port_bench.sv */
// self-checking bench for the serial register access port
`timescale 1ns/1ps
module serial_register_access_port_bench;
    import srap_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic wr_ready = 1'b0;
    logic asel = 1'b0;
    wire logic cs_n, sck, sd;
    logic scl_out, scl_oe, sda_out, sda_oe, sdo_out, sdo_oe, wr_valid, spi_overrun;
    logic [IDX_W-1:0] wr_index, rd_index;
    logic [DATA_W-1:0] wr_data, rd_data;
    wire logic scl_line = sck & ~scl_oe;
    wire logic sda_line = sd & ~sda_oe;
    wire logic sdo_line = sdo_oe ? sdo_out : ~sdo_out;
    int num_errors = 0;
    int samples_checked = 0;
    logic [FIFO_W-1:0] exp_q[$];
    logic [15:0] exp_word;

    always #20 clk = ~clk;
    function automatic logic [7:0] pattern(input logic [6:0] i);
        return {i, 1'b1} ^ 8'h5A;
    endfunction : pattern
    assign rd_data = pattern(rd_index);

    srap_top uut (.clk(clk), .reset(reset), .ce(1'b1), .cs_n(cs_n), .sclk_scl_in(scl_line),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .address_select_pin(asel), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_index(wr_index), .wr_data(wr_data), .rd_index(rd_index),
        .rd_data(rd_data), .spi_overrun(spi_overrun));
    srap_host host (.clk(clk), .cs_n(cs_n), .sck(sck), .sd(sd), .sdo_line(sdo_line),
        .sda_line(sda_line), .scl_line(scl_line));

    // ========
    // checking
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    always @(negedge clk) wr_ready <= ($urandom % 4) != 0;
    always @(posedge clk) begin
        if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
            exp_word = exp_q.size() > 0 ? 16'(exp_q.pop_front()) : 16'hFFFF;
            check("write word", exp_word, {1'b0, wr_index, wr_data});
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    // ========
    // scenarios
    task automatic spi_frame(input logic rd, input int n);
        logic [6:0] idx;
        logic [7:0] d, rx;
        idx = 7'($urandom);
        host.select(1'b0);
        host.spi_byte({rd, idx}, rx);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            if (!rd) exp_q.push_back({7'(idx + i), d});
            host.spi_byte(d, rx);
            if (rd) check("spi read byte", 16'(pattern(7'(idx + i))), 16'(rx));
        end
        host.select(1'b1);
        check("sdo enable", 16'h0, 16'(sdo_oe));
        check("spi overrun", 16'h0, 16'(spi_overrun));
        $display("spi frame done read %0d bytes %0d", rd, n);
    endtask : spi_frame

    task automatic i2c_access(input logic rd, input logic hit);
        logic [6:0] idx;
        logic [7:0] d, rx;
        logic a;
        idx = 7'($urandom);
        d = 8'($urandom);
        asel = 1'($urandom);
        host.start();
        host.i2c_byte({6'h34, asel ^ !hit, 1'b0}, 1'b1, rx, a);
        check("address ack", 16'(!hit), 16'(a));
        if (hit) begin
            host.i2c_byte({1'b0, idx}, 1'b1, rx, a);
            check("index ack", 16'h0, 16'(a));
            if (rd) begin
                host.start();
                host.i2c_byte({6'h34, asel, 1'b1}, 1'b1, rx, a);
                check("read address ack", 16'h0, 16'(a));
                host.i2c_byte(8'hFF, 1'b0, rx, a);
                check("i2c read byte", 16'(pattern(idx)), 16'(rx));
                host.i2c_byte(8'hFF, 1'b1, rx, a);
                check("i2c read next", 16'(pattern(7'(idx + 1))), 16'(rx));
            end else begin
                exp_q.push_back({idx, d});
                host.i2c_byte(d, 1'b1, rx, a);
                check("data ack", 16'h0, 16'(a));
            end
        end
        host.stop();
        check("sda released", 16'h1, 16'(sda_line));
        $display("i2c access done read %0d match %0d", rd, hit);
    endtask : i2c_access

    initial begin
        void'($urandom(32'h0f8b72d6));
        repeat (8) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        for (int n = 1; n <= 3; n++) begin
            spi_frame(1'b0, n);
            spi_frame(1'b1, n);
        end
        i2c_access(1'b0, 1'b1);
        i2c_access(1'b1, 1'b1);
        i2c_access(1'b0, 1'b0);
        for (int w = 0; w < 200 && exp_q.size() > 0; w++) @(negedge clk);
        check("writes drained", 16'h0, 16'(exp_q.size()));
        results();
    end
    initial begin
        #1_000_000;
        num_errors++;
        results();
    end
endmodule : serial_register_access_port_bench

bind srap_top srap_top_sva chk (.clk, .reset, .cs_n, .sclk_scl_in, .scl_out, .scl_oe, .sda_out,
    .sda_oe, .sdo_out, .sdo_oe, .wr_valid, .wr_ready, .wr_index, .wr_data);
